// >>> fru_eeprom_pkg.sv
/*
 Constants for the identity EEPROM block: memory geometry, protected
 region, identity field addresses, bus address defaults and timing.
 Assumes a 20 MHz system clock.
*/
package fru_eeprom_pkg;
	localparam int MEM_BYTES = 8192; // 64 kbit
	localparam int ADDR_W = 13;
	localparam int PAGE_BYTES = 32;
	localparam logic [ADDR_W-1:0] PROT_BASE = 13'h1800; // 6144
	localparam logic [ADDR_W-1:0] ID_END = 13'h19FF;
	localparam logic [ADDR_W-1:0] CUST_BASE = 13'h1862; // 6242
	localparam int CUST_LEN = 158;
	localparam logic [ADDR_W-1:0] K_VOUT_RD = 13'h1900; // 6400
	localparam logic [ADDR_W-1:0] K_IOUT_RD = 13'h1905; // 6405
	localparam logic [ADDR_W-1:0] K_TEMP_RD = 13'h190A; // 6410
	localparam logic [ADDR_W-1:0] K_VOUT_SET = 13'h1914; // 6420
	localparam logic [ADDR_W-1:0] K_VIN_RD = 13'h1919; // 6425
	localparam logic [ADDR_W-1:0] CHKSUM_ADDR = 13'h191E;
	localparam int K_SET_BYTES = 5; // slope hi/lo, offset hi/lo, exponent
	localparam logic [7:0] BLANK_BYTE = 8'hFF;
	localparam logic [7:0] ID_FILL_BYTE = 8'h00;
	localparam logic [2:0] DEFAULT_LOW_BITS = 3'h0;
	localparam int CLK_HZ = 20000000;
	localparam int ADDR_CFG_S = 15;
	localparam int ADDR_CFG_CYC = ADDR_CFG_S * CLK_HZ; // 300e6, fits in int
endpackage

// >>> fru_eeprom_hotplug_access.sv
/*
 Identity EEPROM with hot-plug address configuration and a warning flag.
 Assumes a byte-level bus front end on sys_clk delivering start, byte and
 stop strobes; hardware unlock and fault inputs are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
// Operation
// - After insertion, address configuration takes about fifteen seconds.
// - Until configured, the target answers at its default address with low bits zero.
// - A non-shutdown fault raises a warning while the module keeps running.
// - Provide a 64 kbit byte memory reachable over the bus.
// - Upper quarter protectable; lower three quarters always writable.
// - Protected quarter unlocked when the presence line is driven high.
// - Software write-enable command also unlocks the protected quarter.
// - 32-byte pages; address increments per data byte after the start address.
// - Writes beyond one page wrap to the first address given.
// - Region from 6144 upward holds factory identity data.
// - Customer field of 158 bytes at 6242 in the factory region.
// - Constant sets are five bytes: slope, offset big-endian, then exponent.
// - Readback constant sets start at 6400, 6405 and 6410.
// - Programming set at 6420, input voltage set at 6425.
// - Unused memory reads 0xFF; unspecified identity locations read zero.
// - Checksum is 0xFF minus identity byte sum excluding serial number; the block does not compute it, so it reads zero until written.
module fru_eeprom_hotplug_access
	import fru_eeprom_pkg::*;
#(
	parameter int CFG_CYCLES = ADDR_CFG_CYC, // Shorten in simulation
	parameter logic [3:0] DEV_ADDR_HI = 4'hA, // Arbitrary upper address bits
	parameter logic [2:0] UNIT_ADDR = 3'h5 // Configured low bits, arbitrary
) (
	input wire logic sys_clk, // 20 MHz
	input wire logic nrst, // Async reset, active low
	input wire logic bus_start, // Transaction start pulse
	input wire logic bus_stop, // Transaction stop pulse
	input wire logic bus_byte_vld, // Received byte pulse
	input wire logic [7:0] bus_byte, // Received byte
	input wire logic bus_rd_req, // Read next byte pulse
	input wire logic sw_write_en, // Software write-enable command level
	input wire logic present_pin, // Presence line, high unlocks
	input wire logic sensor_fault_pin, // Non-fatal fault input
	output logic addr_cfg_done, // Address configured
	output logic [6:0] bus_addr, // Address answered on the bus
	output logic addr_match, // Last address byte matched
	output logic [7:0] rd_data, // Read data
	output logic rd_vld, // Read data valid pulse
	output logic warn_out // Predictive warning
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_AHI = 2'b01,
		ST_ALO = 2'b10,
		ST_DATA = 2'b11
	} xfer_state_type;

	logic [7:0] mem [0:MEM_BYTES-1];
	xfer_state_type state_r;
	logic [ADDR_W-1:0] ptr_r;
	logic [ADDR_W-1:0] base_r;
	logic [4:0] page_off_r;
	logic [31:0] cfg_cnt_r;
	logic pres_s1_r, pres_s2_r, flt_s1_r, flt_s2_r;
	logic wr_allow;
	logic [ADDR_W-1:0] wr_addr;
	logic [MEM_BYTES-1:0] wr_done_r;
	logic [7:0] wr_old;

	// Address configuration timer after insertion (power-up)
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cfg_cnt_r <= 32'h0;
			addr_cfg_done <= 1'b0;
		end else if (!addr_cfg_done) begin
			if (cfg_cnt_r == 32'(CFG_CYCLES - 1))
				addr_cfg_done <= 1'b1;
			cfg_cnt_r <= cfg_cnt_r + 32'h1;
		end
	end

	// Default address low bits are zero until configured
	assign bus_addr = {DEV_ADDR_HI, addr_cfg_done ? UNIT_ADDR : DEFAULT_LOW_BITS};

	// Pin synchronisers
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pres_s1_r <= 1'b0;
			pres_s2_r <= 1'b0;
			flt_s1_r <= 1'b0;
			flt_s2_r <= 1'b0;
		end else begin
			pres_s1_r <= present_pin;
			pres_s2_r <= pres_s1_r;
			flt_s1_r <= sensor_fault_pin;
			flt_s2_r <= flt_s1_r;
		end
	end

	// Warning only; nothing here shuts the module down
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			warn_out <= 1'b0;
		else
			warn_out <= flt_s2_r;
	end

	// Transaction sequencer: device address, address high, address low, data
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_r <= ST_IDLE;
			addr_match <= 1'b0;
		end else if (bus_stop) begin
			state_r <= ST_IDLE;
			addr_match <= 1'b0;
		end else if (bus_start) begin
			state_r <= ST_IDLE;
			addr_match <= 1'b0;
		end else if (bus_byte_vld) begin
			case (state_r)
				ST_IDLE: begin
					addr_match <= (bus_byte[7:1] == bus_addr);
					if (bus_byte[7:1] == bus_addr && !bus_byte[0])
						state_r <= ST_AHI;
				end
				ST_AHI: state_r <= ST_ALO;
				ST_ALO: state_r <= ST_DATA;
				ST_DATA: state_r <= ST_DATA;
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Pointer, page base and page offset; wrap inside one page
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ptr_r <= '0;
			base_r <= '0;
			page_off_r <= 5'h0;
		end else if (bus_byte_vld && state_r == ST_AHI) begin
			ptr_r <= {bus_byte[4:0], ptr_r[7:0]};
		end else if (bus_byte_vld && state_r == ST_ALO) begin
			ptr_r <= {ptr_r[12:8], bus_byte};
			base_r <= {ptr_r[12:8], bus_byte};
			page_off_r <= 5'h0;
		end else if (bus_byte_vld && state_r == ST_DATA) begin
			page_off_r <= page_off_r + 5'h1;
		end else if (rd_vld) begin
			ptr_r <= ptr_r + 13'h1;
		end
	end

	// Byte 33 lands on the first address again
	assign wr_addr = base_r + {8'h00, page_off_r};
	// Lower three quarters always writable; top quarter needs an unlock
	assign wr_allow = (wr_addr < PROT_BASE) || pres_s2_r || sw_write_en;

	// Marks bytes written since reset; the array itself keeps a single driver
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst)
			wr_done_r <= '0;
		else if (bus_byte_vld && state_r == ST_DATA && wr_allow)
			wr_done_r[wr_addr] <= 1'b1;
	end

	// Array write; locked writes are acknowledged upstream but dropped
	always_ff @(posedge sys_clk) begin
		if (bus_byte_vld && state_r == ST_DATA && wr_allow)
			mem[wr_addr] <= bus_byte;
	end

	// Stored byte: blank outside identity, zero inside until written.
	// Limitation: the cells are volatile, so a reset restores this image;
	// constant sets and checksum are not preloaded, so they read zero until written
	function automatic logic [7:0] stored_byte(input logic [ADDR_W-1:0] a);
		if (wr_done_r[a])
			return mem[a];
		else if (a >= PROT_BASE && a <= ID_END)
			return ID_FILL_BYTE;
		else
			return BLANK_BYTE;
	endfunction

	// Byte held at the write address before the write lands
	always_comb begin
		wr_old = stored_byte(wr_addr);
	end

	// Reads continue from the current pointer
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rd_data <= 8'h00;
			rd_vld <= 1'b0;
		end else begin
			rd_vld <= bus_rd_req;
			if (bus_rd_req)
				rd_data <= stored_byte(ptr_r);
		end
	end

	// Multi-step behaviours watched below
	sequence s_fault_held;
		$rose(sensor_fault_pin) ##1 sensor_fault_pin [*2];
	endsequence
	sequence s_fault_gone;
		$fell(sensor_fault_pin) ##1 !sensor_fault_pin [*2];
	endsequence
	sequence s_dev_hit;
		bus_byte_vld && !bus_start && !bus_stop && state_r == ST_IDLE && bus_byte == {bus_addr, 1'b0};
	endsequence

	// Configuration flag holds until the full interval has passed
	a_cfg_time: assert property (@(posedge sys_clk) disable iff (!nrst)
		$rose(addr_cfg_done) |-> cfg_cnt_r == 32'(CFG_CYCLES)) else $error("address configured early");
	a_default_addr: assert property (@(posedge sys_clk) disable iff (!nrst)
		!addr_cfg_done |-> bus_addr[2:0] == 3'h0) else $error("default address low bits not zero");
	a_warn_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_fault_held |=> warn_out) else $error("warning missing");
	a_warn_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_fault_gone |=> !warn_out) else $error("warning stuck");
	a_dev_match: assert property (@(posedge sys_clk) disable iff (!nrst)
		s_dev_hit |=> state_r == ST_AHI && addr_match) else $error("own address ignored");
	a_dev_miss: assert property (@(posedge sys_clk) disable iff (!nrst)
		(bus_byte_vld && !bus_start && !bus_stop && state_r == ST_IDLE && bus_byte[7:1] != bus_addr)
		|=> state_r == ST_IDLE && !addr_match) else $error("foreign address taken");
	// Checks the stored byte, not the enable term, so a broken gate shows up
	a_locked_keep: assert property (@(posedge sys_clk) disable iff (!nrst)
		(bus_byte_vld && state_r == ST_DATA && wr_addr >= PROT_BASE && !pres_s2_r && !sw_write_en)
		|=> stored_byte($past(wr_addr)) == $past(wr_old)) else $error("locked write landed");
	a_low_writable: assert property (@(posedge sys_clk) disable iff (!nrst)
		(bus_byte_vld && state_r == ST_DATA && wr_addr < PROT_BASE)
		|=> stored_byte($past(wr_addr)) == $past(bus_byte)) else $error("low region blocked");
	a_rd_incr: assert property (@(posedge sys_clk) disable iff (!nrst)
		(rd_vld && !bus_byte_vld) |=> ptr_r == $past(ptr_r) + 13'h1) else $error("read pointer stuck");
	a_page_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
		(bus_byte_vld && state_r == ST_DATA && page_off_r == 5'h1F) |=> wr_addr == base_r) else $error("no wrap");
	a_sw_unlock: assert property (@(posedge sys_clk) disable iff (!nrst)
		(bus_byte_vld && state_r == ST_DATA && sw_write_en)
		|=> stored_byte($past(wr_addr)) == $past(bus_byte)) else $error("software unlock ignored");
	a_rd_valid: assert property (@(posedge sys_clk) disable iff (!nrst)
		bus_rd_req |=> rd_vld ##1 !rd_vld || $past(bus_rd_req)) else $error("read strobe wrong");
endmodule
`default_nettype wire

// >>> mgmt_ctrl_model.sv
/*
 Behavioural management controller: byte-level bus transactions.
 Assumes the block samples strobes on the rising edge of sys_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module mgmt_ctrl_model (
	input wire logic sys_clk, // Block clock
	output logic bus_start, // Start pulse
	output logic bus_stop, // Stop pulse
	output logic bus_byte_vld, // Byte strobe
	output logic [7:0] bus_byte, // Byte value
	output logic bus_rd_req, // Read request
	input wire logic rd_vld, // Read valid
	input wire logic [7:0] rd_data // Read byte
);
	// Idle bus shows the inverse of the last byte, never a stale value
	initial begin
		{bus_start, bus_stop, bus_byte_vld, bus_rd_req} = 4'h0;
		bus_byte = 8'h00;
	end
	// Line select: 0 start, 1 stop, other read request; high for one cycle
	task automatic pulse(input int which);
		@(posedge sys_clk);
		#1;
		case (which)
			0: bus_start = 1'b1;
			1: bus_stop = 1'b1;
			default: bus_rd_req = 1'b1;
		endcase
		@(posedge sys_clk);
		#1;
		{bus_start, bus_stop, bus_rd_req} = 3'h0;
	endtask
	task automatic send(input logic [7:0] b);
		@(posedge sys_clk); #1 bus_byte_vld = 1'b1;
		bus_byte = b;
		@(posedge sys_clk); #1 bus_byte_vld = 1'b0;
		bus_byte = ~b;
	endtask
	// Header only (n of 0) leaves the transfer open for reads
	task automatic wr(input logic [6:0] dev, input logic [12:0] a, input int n, input logic [7:0] d0);
		pulse(0);
		send({dev, 1'b0});
		send({3'h0, a[12:8]});
		send(a[7:0]);
		for (int i = 0; i < n; i++) send(d0 + 8'(i));
		if (n != 0) pulse(1);
	endtask
	// Answer is taken in the cycle after the request
	task automatic rd(output logic [7:0] d);
		pulse(2);
		d = (rd_vld === 1'b1) ? rd_data : 8'hXX;
	endtask
endmodule
`default_nettype wire

// >>> fru_eeprom_hotplug_access_test.sv
/*
 Self-checking bench for the identity EEPROM block.
 Assumes a shortened configuration count and a behavioural controller.
*/
`timescale 1ns/1ps
`default_nettype none
module fru_eeprom_hotplug_access_test;
	import fru_eeprom_pkg::*;
	localparam int CFG = 20;
	localparam logic [3:0] HI = 4'hA;
	localparam logic [2:0] LO = 3'h5;
	logic sys_clk, nrst, bus_start, bus_stop, bus_byte_vld, bus_rd_req, sw_write_en, present_pin, sensor_fault_pin;
	logic addr_cfg_done, addr_match, rd_vld, warn_out;
	logic [7:0] bus_byte, rd_data, d;
	logic [6:0] bus_addr, dev;
	int num_errors = 0;
	int n_tests = 0;
	int cyc = 0;
	fru_eeprom_hotplug_access #(.CFG_CYCLES(CFG), .DEV_ADDR_HI(HI), .UNIT_ADDR(LO)) i_fru_eeprom_hotplug_access (
		.sys_clk(sys_clk), .nrst(nrst), .bus_start(bus_start), .bus_stop(bus_stop),
		.bus_byte_vld(bus_byte_vld), .bus_byte(bus_byte), .bus_rd_req(bus_rd_req),
		.sw_write_en(sw_write_en), .present_pin(present_pin), .sensor_fault_pin(sensor_fault_pin),
		.addr_cfg_done(addr_cfg_done), .bus_addr(bus_addr), .addr_match(addr_match),
		.rd_data(rd_data), .rd_vld(rd_vld), .warn_out(warn_out));
	mgmt_ctrl_model i_mgmt_ctrl_model (.sys_clk(sys_clk), .bus_start(bus_start), .bus_stop(bus_stop),
		.bus_byte_vld(bus_byte_vld), .bus_byte(bus_byte), .bus_rd_req(bus_rd_req),
		.rd_vld(rd_vld), .rd_data(rd_data));
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	// Cut a hang short well past the expected run length
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			num_errors++;
			$display("[ERR] %0t timeout", $time);
			print_verdict();
		end
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string m);
		n_tests++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask
	task automatic rdat(input logic [12:0] a, input logic [7:0] e, input string m);
		i_mgmt_ctrl_model.wr(dev, a, 0, 8'h00);
		chk({7'h0, addr_match}, 8'h01, "address match");
		i_mgmt_ctrl_model.rd(d);
		chk(d, e, m);
	endtask
	task automatic print_verdict;
		$display("tests %0d errors %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// Traffic waits for configuration so no default-address clash occurs
	task automatic t_cfg;
		int k;
		chk({1'b0, bus_addr}, {1'b0, HI, 3'h0}, "default address");
		// Look just after each edge, so the count is exact
		for (k = 0; k < CFG + 10 && addr_cfg_done !== 1'b1; k++) begin
			@(posedge sys_clk);
			#1;
		end
		chk({7'h0, addr_cfg_done}, 8'h01, "config done");
		chk(8'(k), 8'(CFG), "config interval");
		chk({1'b0, bus_addr}, {1'b0, HI, LO}, "configured address");
		dev = {HI, LO};
		$display("t_cfg done");
	endtask
	task automatic t_page;
		rdat(13'h0000, BLANK_BYTE, "blank area");
		rdat(13'h1862, ID_FILL_BYTE, "identity fill");
		i_mgmt_ctrl_model.wr(dev, 13'h0010, 33, 8'h40);
		rdat(13'h0010, 8'h60, "wrapped byte");
		i_mgmt_ctrl_model.rd(d);
		chk(d, 8'h41, "increment");
		// Header left open, so a wrong match would still show on the flag
		i_mgmt_ctrl_model.wr({HI, 3'h0}, 13'h0040, 0, 8'h00);
		chk({7'h0, addr_match}, 8'h00, "stale header matched");
		i_mgmt_ctrl_model.wr({HI, 3'h0}, 13'h0040, 1, 8'h33);
		chk({7'h0, addr_match}, 8'h00, "stale address matched");
		rdat(13'h0040, 8'hFF, "foreign write landed");
		$display("t_page done");
	endtask
	task automatic t_prot;
		i_mgmt_ctrl_model.wr(dev, 13'h17FF, 1, 8'h11);
		rdat(13'h17FF, 8'h11, "lower quarter");
		i_mgmt_ctrl_model.wr(dev, 13'h1800, 1, 8'h5A);
		rdat(13'h1800, 8'h00, "locked write");
		#1 sw_write_en = 1'b1;
		i_mgmt_ctrl_model.wr(dev, 13'h1900, 1, 8'h77);
		sw_write_en = 1'b0;
		rdat(K_VOUT_RD, 8'h77, "software unlock");
		present_pin = 1'b1;
		repeat (3) @(posedge sys_clk);
		i_mgmt_ctrl_model.wr(dev, 13'h1919, 1, 8'h66);
		present_pin = 1'b0;
		rdat(K_VIN_RD, 8'h66, "pin unlock");
		$display("t_prot done");
	endtask
	task automatic t_warn;
		@(posedge sys_clk); #1 sensor_fault_pin = 1'b1;
		repeat (2) @(posedge sys_clk); #1 chk({7'h0, warn_out}, 8'h00, "warn early");
		repeat (2) @(posedge sys_clk); #1 chk({7'h0, warn_out}, 8'h01, "warn missing");
		sensor_fault_pin = 1'b0;
		repeat (4) @(posedge sys_clk); #1 chk({7'h0, warn_out}, 8'h00, "warn stuck");
		$display("t_warn done");
	endtask
	// Unit pulled after its service indicator was lit, then reseated
	task automatic t_replug;
		@(posedge sys_clk); #1 nrst = 1'b0;
		@(posedge sys_clk); #1 nrst = 1'b1;
		chk({7'h0, addr_cfg_done}, 8'h00, "reinsert config flag");
		t_cfg();
		rdat(13'h0000, BLANK_BYTE, "after reinsertion");
		$display("t_replug done");
	endtask
	initial begin
		{nrst, sw_write_en, present_pin, sensor_fault_pin} = 4'h0;
		dev = {HI, 3'h0};
		repeat (2) @(posedge sys_clk);
		#1 nrst = 1'b1;
		t_cfg();
		t_page();
		t_prot();
		t_warn();
		t_replug();
		print_verdict();
	end
endmodule
`default_nettype wire
